// ---- hw/mgr_pkg.sv ----
package mgr_pkg;
    localparam int NUM_CHANNELS = 16;
    localparam int NUM_LAYERS = 4;
    localparam logic [1:0] DEFAULT_BASIC_MODE = 2'h2;
    localparam logic [3:0] STATUS_CTRL = 4'hb;
    localparam logic [3:0] STATUS_SYSTEM = 4'hf;
    localparam logic [6:0] CC_DATA_ENTRY = 7'h06;
    localparam logic [6:0] CC_RPN_MSB = 7'h65;
    localparam logic [6:0] CC_RPN_LSB = 7'h64;
    localparam logic [6:0] CC_RESET_CTRL = 7'h79;
    localparam logic [6:0] CC_LOCAL = 7'h7a;
    localparam logic [6:0] CC_ALL_OFF = 7'h7b;
    localparam logic [6:0] RPN_NULL = 7'h7f;
    localparam logic [6:0] RPN_MSB_SELECT = 7'h00;
    localparam logic [6:0] RPN_BEND_RANGE = 7'h00;
    localparam logic [6:0] RPN_FINE_TUNE = 7'h01;
    localparam logic [6:0] RPN_COARSE_TUNE = 7'h02;
    localparam logic [1:0] DETUNE_NORMAL = 2'h0;
    typedef enum logic [1:0] {
        MGR_IDLE = 2'b00,
        MGR_CTRL = 2'b01,
        MGR_VAL = 2'b11
    } mgr_state_type;
endpackage

// ---- hw/mgr_layer_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module mgr_layer_regs #(
    parameter int WIDTH = 7
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [WIDTH-1:0] value,
    output logic [WIDTH-1:0] layerValue
);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            layerValue <= '0;
        end else if (load) begin
            layerValue <= value;
        end
    end
endmodule
`default_nettype wire

// ---- hw/mgr_receiver.sv ----
`timescale 1ns/1ps
`default_nettype none
// Function
// [R1] every one of 16 channels receives and drives its own program
// [R2] basic mode after reset is mode 3, omni off poly
// [R3] registered parameters act only in multi-part GM play; only 0, 1, 2
// [R4] parameter 0 writes pitch wheel range of all four layers
// [R5] parameter 1 writes detune amount of all four layers
// [R6] parameter 1 also forces detune type normal on all layers
// [R7] parameter 2 writes semitone tuning of all four layers
// [R8] any applied parameter sets that program's edited flag
// [R9] sender selects parameter by controllers 100, 101 then data entry
// [R10] system common and realtime bytes ignored, nothing transmitted; system common bytes return the parser to idle
// [R11] local and reset-controllers act as all notes off; GM on accepted
module mgr_receiver #(
    parameter int CHANNELS = mgr_pkg::NUM_CHANNELS,
    parameter int LAYERS = mgr_pkg::NUM_LAYERS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic rxValid,
    input wire logic [7:0] rxByte,
    input wire logic multiPart,
    input wire logic gmEnable,
    input wire logic gmOnIn,
    input wire logic editClear,
    input wire logic [3:0] editClearChannel,
    output logic [1:0] basicMode,
    output logic gmActive,
    output logic notesOffPulse,
    output logic [3:0] notesOffChannel,
    output logic [CHANNELS*LAYERS*7-1:0] bendRange,
    output logic [CHANNELS*LAYERS*7-1:0] detuneAmount,
    output logic [CHANNELS*LAYERS*2-1:0] detuneType,
    output logic [CHANNELS*LAYERS*7-1:0] semitone,
    output logic [CHANNELS-1:0] edited,
    output logic txValid
);
    mgr_pkg::mgr_state_type state;
    logic [3:0] channel;
    logic [6:0] ctrlNum;
    logic [6:0] rpnMsb [CHANNELS];
    logic [6:0] rpnLsb [CHANNELS];
    logic dataStrobe;
    logic [6:0] dataValue;
    logic [CHANNELS-1:0] applyBend, applyFine, applyCoarse;
    logic rpnAllowed;

    assign txValid = 1'b0; // R10
    assign rpnAllowed = multiPart && gmEnable; // R3

    // basic mode is fixed; no mode message alters it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            basicMode <= mgr_pkg::DEFAULT_BASIC_MODE; // R2
        end else begin
            basicMode <= mgr_pkg::DEFAULT_BASIC_MODE; // R2
        end
    end

    // gm on is decoded upstream; the flag stays until reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gmActive <= 1'b0;
        end else if (gmOnIn) begin
            gmActive <= 1'b1; // R11
        end
    end

    // running-status parser; only controller messages are decoded
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= mgr_pkg::MGR_IDLE;
            channel <= '0;
            ctrlNum <= '0;
        end else if (rxValid) begin
            if (rxByte[7]) begin
                if (rxByte[7:4] == mgr_pkg::STATUS_SYSTEM) begin
                    if (rxByte[3] == 1'b0) begin
                        state <= mgr_pkg::MGR_IDLE; // R10
                    end
                end else if (rxByte[7:4] == mgr_pkg::STATUS_CTRL) begin
                    state <= mgr_pkg::MGR_CTRL;
                    channel <= rxByte[3:0]; // R1
                end else begin
                    state <= mgr_pkg::MGR_IDLE;
                end
            end else begin
                case (state)
                    mgr_pkg::MGR_CTRL: begin
                        ctrlNum <= rxByte[6:0];
                        state <= mgr_pkg::MGR_VAL;
                    end
                    mgr_pkg::MGR_VAL: state <= mgr_pkg::MGR_CTRL;
                    default: state <= mgr_pkg::MGR_IDLE;
                endcase
            end
        end
    end

    wire ctrlDone = rxValid && !rxByte[7] && state == mgr_pkg::MGR_VAL;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int c = 0; c < CHANNELS; c++) begin
                rpnMsb[c] <= mgr_pkg::RPN_NULL;
                rpnLsb[c] <= mgr_pkg::RPN_NULL;
            end
        end else if (ctrlDone) begin
            if (ctrlNum == mgr_pkg::CC_RPN_MSB) begin
                rpnMsb[channel] <= rxByte[6:0]; // R9
            end
            if (ctrlNum == mgr_pkg::CC_RPN_LSB) begin
                rpnLsb[channel] <= rxByte[6:0]; // R9
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            notesOffPulse <= 1'b0;
            notesOffChannel <= '0;
        end else begin
            notesOffPulse <= ctrlDone && (ctrlNum == mgr_pkg::CC_ALL_OFF
                || ctrlNum == mgr_pkg::CC_LOCAL
                || ctrlNum == mgr_pkg::CC_RESET_CTRL); // R11
            if (ctrlDone) begin
                notesOffChannel <= channel;
            end
        end
    end

    assign dataStrobe = ctrlDone && ctrlNum == mgr_pkg::CC_DATA_ENTRY
        && rpnAllowed && rpnMsb[channel] == mgr_pkg::RPN_MSB_SELECT; // R3
    assign dataValue = rxByte[6:0];

    always_comb begin
        applyBend = '0;
        applyFine = '0;
        applyCoarse = '0;
        if (dataStrobe) begin
            applyBend[channel] =
                rpnLsb[channel] == mgr_pkg::RPN_BEND_RANGE; // R4
            applyFine[channel] =
                rpnLsb[channel] == mgr_pkg::RPN_FINE_TUNE; // R5
            applyCoarse[channel] =
                rpnLsb[channel] == mgr_pkg::RPN_COARSE_TUNE; // R7
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS * LAYERS; g++) begin : gLayer
            mgr_layer_regs #(.WIDTH(7)) uBend (
                .clk(clk), .reset(reset), .load(applyBend[g / LAYERS]),
                .value(dataValue), .layerValue(bendRange[g*7 +: 7])); // R4
            mgr_layer_regs #(.WIDTH(7)) uFine (
                .clk(clk), .reset(reset), .load(applyFine[g / LAYERS]),
                .value(dataValue),
                .layerValue(detuneAmount[g*7 +: 7])); // R5
            mgr_layer_regs #(.WIDTH(2)) uType (
                .clk(clk), .reset(reset), .load(applyFine[g / LAYERS]),
                .value(mgr_pkg::DETUNE_NORMAL),
                .layerValue(detuneType[g*2 +: 2])); // R6
            mgr_layer_regs #(.WIDTH(7)) uCoarse (
                .clk(clk), .reset(reset), .load(applyCoarse[g / LAYERS]),
                .value(dataValue), .layerValue(semitone[g*7 +: 7])); // R7
        end
    endgenerate

    // set wins over clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            edited <= '0;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (applyBend[c] || applyFine[c] || applyCoarse[c]) begin
                    edited[c] <= 1'b1; // R8
                end else if (editClear && editClearChannel == c[3:0]) begin
                    edited[c] <= 1'b0;
                end
            end
        end
    end

    sequence s_rpnApply;
        dataStrobe && rpnLsb[channel] == mgr_pkg::RPN_FINE_TUNE;
    endsequence

    chk_fine_type: assert property (@(posedge clk) disable iff (reset) // R6
        s_rpnApply |=> detuneType[$past(channel)*LAYERS*2 +: 2] ==
            mgr_pkg::DETUNE_NORMAL)
        else $error("detune type not forced normal");
    chk_rpn_gate: assert property (@(posedge clk) disable iff (reset) // R3
        !rpnAllowed && !editClear |=> $stable(edited))
        else $error("parameter applied outside multi-part gm");
    chk_edit_set: assert property (@(posedge clk) disable iff (reset) // R8
        dataStrobe && rpnLsb[channel] <= mgr_pkg::RPN_COARSE_TUNE
            |=> edited[$past(channel)])
        else $error("edited flag not set");
    chk_bend_write: assert property (@(posedge clk) disable iff (reset) // R4
        applyBend != '0 |=> bendRange[$past(channel)*LAYERS*7 +: 7] ==
            $past(dataValue))
        else $error("bend range not written");
    chk_coarse_write: assert property (@(posedge clk) disable iff (reset) // R7
        applyCoarse != '0 |=> semitone[$past(channel)*LAYERS*7 +: 7] ==
            $past(dataValue))
        else $error("semitone not written");
    chk_fine_write: assert property (@(posedge clk) disable iff (reset) // R5
        applyFine != '0 |=> detuneAmount[$past(channel)*LAYERS*7 +: 7] ==
            $past(dataValue))
        else $error("detune amount not written");
    chk_notes_off: assert property (@(posedge clk) disable iff (reset) // R11
        ctrlDone && ctrlNum == mgr_pkg::CC_LOCAL |=> notesOffPulse ##1
            !notesOffPulse)
        else $error("local control did not stop notes");
    chk_off_channel: assert property (@(posedge clk) disable iff (reset) // R11
        ctrlDone |=> notesOffChannel == $past(channel))
        else $error("notes off channel wrong");
    chk_rt_ignored: assert property (@(posedge clk) disable iff (reset) // R10
        rxValid && rxByte[7:4] == mgr_pkg::STATUS_SYSTEM && rxByte[3]
            |=> $stable(state))
        else $error("realtime byte disturbed the parser");
    chk_no_tx: assert property (@(posedge clk) disable iff (reset) // R10
        !txValid)
        else $error("device transmitted");
    chk_mode_kept: assert property (@(posedge clk) disable iff (reset) // R2
        basicMode == mgr_pkg::DEFAULT_BASIC_MODE)
        else $error("basic mode changed");
endmodule
`default_nettype wire

// ---- tb/mgr_sender.sv ----
`timescale 1ns/1ps
`default_nettype none
module mgr_sender (
    input wire logic clk,
    output logic rxValid,
    output logic [7:0] rxByte
);
    initial begin
        rxValid = 1'b0;
        rxByte = 8'h00;
    end
    // one byte every other cycle; a released data line shows the inverse
    task automatic put(input logic [7:0] b);
        @(negedge clk);
        rxValid = 1'b1;
        rxByte = b;
        @(negedge clk);
        rxValid = 1'b0;
        rxByte = ~b;
    endtask
    // select with 101 and 100, then data entry
    task automatic rpn(input logic [3:0] ch, input logic [6:0] sel,
                       input logic [6:0] v, input logic rt);
        put({4'hb, ch});
        put(8'h65);
        put(8'h00);
        put(8'h64);
        put({1'b0, sel});
        if (rt) begin
            put(8'hf8);
        end
        put(8'h06);
        put({1'b0, v});
    endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, reset, rxValid, multiPart, gmEnable, gmOnIn, editClear;
    logic [7:0] rxByte;
    logic [3:0] editClearChannel, notesOffChannel;
    logic [1:0] basicMode;
    logic gmActive, notesOffPulse, txValid;
    logic [447:0] bendRange, detuneAmount, semitone;
    logic [127:0] detuneType;
    logic [15:0] edited;
    int miscompares = 0;
    int n_compared = 0;
    typedef struct {
        logic [3:0] ch;
        logic [6:0] sel, v, b, d, s;
        logic ed;
    } mgr_row_type;
    // channel, parameter, value, then expected bend, detune, semitone, edited
    mgr_row_type rows [5] = '{
        '{4'h3, 7'h01, 7'h40, 7'h00, 7'h40, 7'h00, 1'b1},
        '{4'h0, 7'h00, 7'h0c, 7'h0c, 7'h00, 7'h00, 1'b1},
        '{4'hf, 7'h02, 7'h7f, 7'h00, 7'h00, 7'h7f, 1'b1},
        '{4'h9, 7'h03, 7'h55, 7'h00, 7'h00, 7'h00, 1'b0},
        '{4'h5, 7'h7f, 7'h21, 7'h00, 7'h00, 7'h00, 1'b0}};
    mgr_receiver uut (.clk(clk), .reset(reset), .rxValid(rxValid),
        .rxByte(rxByte), .multiPart(multiPart), .gmEnable(gmEnable),
        .gmOnIn(gmOnIn), .editClear(editClear),
        .editClearChannel(editClearChannel), .basicMode(basicMode),
        .gmActive(gmActive), .notesOffPulse(notesOffPulse),
        .notesOffChannel(notesOffChannel), .bendRange(bendRange),
        .detuneAmount(detuneAmount), .detuneType(detuneType),
        .semitone(semitone), .edited(edited), .txValid(txValid));
    mgr_sender snd (.clk(clk), .rxValid(rxValid), .rxByte(rxByte));
    task automatic give_verdict();
        if (miscompares == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cmpv(input logic [6:0] got, input logic [6:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t value %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmpf(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t flag %b want %b", $time, got, exp);
        end
    endtask
    // all four layers of one channel against expected values
    task automatic layers(input logic [3:0] ch, input logic [6:0] b,
                          input logic [6:0] d, input logic [6:0] s);
        for (int l = 0; l < 4; l++) begin
            cmpv(bendRange[(ch*4+l)*7 +: 7], b);
            cmpv(detuneAmount[(ch*4+l)*7 +: 7], d);
            cmpv({5'h00, detuneType[(ch*4+l)*2 +: 2]}, 7'h00);
            cmpv(semitone[(ch*4+l)*7 +: 7], s);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
    initial begin
        reset = 1'b1;
        {multiPart, gmEnable, gmOnIn, editClear} = 4'hc;
        editClearChannel = 4'h0;
        repeat (20) @(negedge clk);
        reset = 1'b0;
        cmpv({5'h00, basicMode}, 7'h02);
        cmpf(txValid, 1'b0);
        cmpf(gmActive, 1'b0);
        foreach (rows[i]) begin
            snd.rpn(rows[i].ch, rows[i].sel, rows[i].v, 1'b0);
            @(negedge clk);
            layers(rows[i].ch, rows[i].b, rows[i].d, rows[i].s);
            cmpf(edited[rows[i].ch], rows[i].ed);
        end
        multiPart = 1'b0;
        snd.rpn(4'h1, 7'h00, 7'h11, 1'b0);
        @(negedge clk);
        layers(4'h1, 7'h00, 7'h00, 7'h00);
        cmpf(edited[1], 1'b0);
        multiPart = 1'b1;
        snd.rpn(4'h2, 7'h00, 7'h22, 1'b1);
        @(negedge clk);
        layers(4'h2, 7'h22, 7'h00, 7'h00);
        snd.put(8'hb4);
        snd.put(8'h79);
        snd.put(8'h00);
        cmpf(notesOffPulse, 1'b1);
        cmpv({3'h0, notesOffChannel}, 7'h04);
        @(negedge clk);
        cmpf(notesOffPulse, 1'b0);
        gmOnIn = 1'b1;
        @(negedge clk);
        gmOnIn = 1'b0;
        @(negedge clk);
        cmpf(gmActive, 1'b1);
        cmpf(txValid, 1'b0);
        gmEnable = 1'b0;
        snd.rpn(4'h7, 7'h02, 7'h13, 1'b0);
        @(negedge clk);
        layers(4'h7, 7'h00, 7'h00, 7'h00);
        cmpf(edited[7], 1'b0);
        gmEnable = 1'b1;
        // a nonzero parameter msb selects nothing
        snd.put(8'hb6);
        snd.put(8'h65);
        snd.put(8'h01);
        snd.put(8'h64);
        snd.put(8'h00);
        snd.put(8'h06);
        snd.put(8'h33);
        @(negedge clk);
        layers(4'h6, 7'h00, 7'h00, 7'h00);
        cmpf(edited[6], 1'b0);
        snd.put(8'h7a);
        snd.put(8'h00);
        cmpf(notesOffPulse, 1'b1);
        cmpv({3'h0, notesOffChannel}, 7'h06);
        snd.put(8'h7b);
        snd.put(8'h00);
        cmpf(notesOffPulse, 1'b1);
        snd.put(8'h07);
        snd.put(8'h00);
        cmpf(notesOffPulse, 1'b0);
        // clear held across the applying edge: the set wins
        snd.put(8'hb0);
        snd.put(8'h06);
        editClear = 1'b1;
        snd.put(8'h2a);
        editClear = 1'b0;
        @(negedge clk);
        cmpf(edited[0], 1'b1);
        layers(4'h0, 7'h2a, 7'h00, 7'h00);
        editClear = 1'b1;
        @(negedge clk);
        editClear = 1'b0;
        @(negedge clk);
        cmpf(edited[0], 1'b0);
        cmpf(edited[3], 1'b1);
        // reset in mid-run clears settings and parameter selects
        reset = 1'b1;
        @(negedge clk);
        reset = 1'b0;
        cmpf(edited[3], 1'b0);
        cmpf(gmActive, 1'b0);
        cmpv({5'h00, basicMode}, 7'h02);
        layers(4'h3, 7'h00, 7'h00, 7'h00);
        snd.rpn(4'h3, 7'h01, 7'h05, 1'b0);
        @(negedge clk);
        layers(4'h3, 7'h00, 7'h05, 7'h00);
        cmpf(edited[3], 1'b1);
        give_verdict();
    end
endmodule
`default_nettype wire
